// >>> amp_frontend_pkg.sv
package amp_frontend_pkg;

   localparam int NUM_CH = 4;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Per-channel register offsets, channel 0 first.
   localparam logic [ADDR_W-1:0] CTL_OFF  [NUM_CH] =
      '{12'h020, 12'h070, 12'h0a0, 12'h0d0};
   localparam logic [ADDR_W-1:0] CHOP_OFF [NUM_CH] =
      '{12'h024, 12'h074, 12'h0a4, 12'h028};

   // Reset values and writable-bit masks; unmasked bits read as zero.
   localparam logic [DATA_W-1:0] CTL_RST  [NUM_CH] =
      '{32'h0000_0009, 32'h0000_0011, 32'h0000_0019, 32'h0000_0011};
   localparam logic [DATA_W-1:0] CTL_MASK [NUM_CH] =
      '{32'h0000_5fff, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_7fff};
   localparam logic [DATA_W-1:0] CHOP_RST  = 32'h0000_0001;
   localparam logic [DATA_W-1:0] CHOP_MASK = 32'h0000_0001;

   // Channels that own an external filter capacitor.
   localparam logic [NUM_CH-1:0] CAP_PRESENT = 4'h5;

   // Field positions in the control and chop registers.
   localparam int PD_BIT     = 0;
   localparam int MODE_BIT   = 1;
   localparam int COUPLE_BIT = 2;
   localparam int CAP_BIT    = 3;
   localparam int GAIN_LSB   = 5;
   localparam int RES_LSB    = 8;
   localparam int BIAS_LSB   = 11;
   localparam int BOOST_BIT  = 14;
   localparam int CHOP_BIT   = 0;

   // Field values that get their own meaning.
   localparam logic [2:0] RES_CODE_UNDEF = 3'h7;

   typedef struct packed {
      logic       sink_boost_en;
      logic [1:0] transimp_bias_sel;
      logic [2:0] transimp_resistor_sel;
      logic [2:0] voltage_gain_sel;
      logic       filter_cap_bypass;
      logic       coupling_mode_sel;
      logic       tia_mode;
      logic       amp_core_powerdown;
      logic       chop_disable;
   } amp_cfg_t;

   typedef struct packed {
      logic [3:0]  gain_value;
      logic [16:0] resistor_ohms;
      logic        resistor_valid;
      logic        sample_time_x2;
   } amp_decode_t;

endpackage

// >>> amp_channel_regs.sv
`timescale 1ns/1ps
module amp_channel_regs
   import amp_frontend_pkg::*;
#(
   parameter logic [31:0] CTL_RESET = 32'h0000_0001,
   parameter logic [31:0] CTL_WMASK = 32'h0000_7fff,
   parameter bit          HAS_CAP   = 1'b0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ctl_we,
   input  wire logic        chop_we,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic      [31:0] ctl_q,
   output logic      [31:0] chop_q,
   output amp_cfg_t         cfg
);

   logic [31:0] ctl_reg;
   logic [31:0] ctl_next;
   logic [31:0] chop_reg;
   logic [31:0] chop_next;
   logic [31:0] lane_mask;

   always_comb begin
      lane_mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}},
                   {8{wstrb[0]}}};
      ctl_next  = ctl_reg;
      chop_next = chop_reg;
      // Read-only bits are never in the mask, so they keep zero.
      if (ctl_we) begin
         ctl_next = (ctl_reg & ~(CTL_WMASK & lane_mask)) |
                    (wdata & CTL_WMASK & lane_mask);
      end
      if (chop_we) begin
         chop_next = (chop_reg & ~(CHOP_MASK & lane_mask)) |
                     (wdata & CHOP_MASK & lane_mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg  <= CTL_RESET;
         chop_reg <= CHOP_RST;
      end else begin
         ctl_reg  <= ctl_next;
         chop_reg <= chop_next;
      end
   end

   assign ctl_q  = ctl_reg;
   assign chop_q = chop_reg;

   assign cfg.amp_core_powerdown    = ctl_reg[PD_BIT];
   assign cfg.tia_mode              = ctl_reg[MODE_BIT];
   assign cfg.coupling_mode_sel     = ctl_reg[COUPLE_BIT];
   // Without a capacitor pin the path is always bypassed.
   assign cfg.filter_cap_bypass     = HAS_CAP ? ctl_reg[CAP_BIT]
                                              : 1'b1;
   assign cfg.voltage_gain_sel      = ctl_reg[GAIN_LSB +: 3];
   assign cfg.transimp_resistor_sel = ctl_reg[RES_LSB +: 3];
   assign cfg.transimp_bias_sel     = ctl_reg[BIAS_LSB +: 2];
   assign cfg.sink_boost_en         = ctl_reg[BOOST_BIT];
   assign cfg.chop_disable          = chop_reg[CHOP_BIT];

endmodule

// >>> amp_frontend_control_regs.sv
`timescale 1ns/1ps
// Function
// - Control bit 1 selects voltage gain (0) or transimpedance (1), reset 0.
// - Control bit 0 powers the amplifier core down when 1, reset 1.
// - Gain field bits 7:5 maps codes 0..5 to gains 1,2,4,6,8,10.
// - Resistor field bits 10:8 maps codes 0..6 to 250 ohm..100k; 7 undefined.
// - Bias field bits 12:11 picks one of four bias converters, reset 0.
// - Bit 14 enables boosted sink current in transimpedance mode, reset 0.
// - Bit 2 selects coupling: 0 is DC, 1 is AC, reset 0.
// - Channels 0 and 2 bit 3 bypasses external capacitor when 1, reset 1.
// - Chop bit 0 low enables chopping and doubles converter sample time.
module amp_frontend_control_regs
   import amp_frontend_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [ADDR_W-1:0]        paddr,
   input  wire logic [DATA_W-1:0]        pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [DATA_W-1:0]        prdata,
   output logic                          pready,
   output logic                          pslverr,
   output amp_cfg_t    [NUM_CH-1:0]      amp_cfg,
   output amp_decode_t [NUM_CH-1:0]      amp_decode
);

   logic [NUM_CH-1:0] ctl_hit;
   logic [NUM_CH-1:0] chop_hit;
   logic [NUM_CH-1:0] ctl_we;
   logic [NUM_CH-1:0] chop_we;
   logic [DATA_W-1:0] ctl_q  [NUM_CH];
   logic [DATA_W-1:0] chop_q [NUM_CH];
   logic              setup_phase;
   logic              access_phase;
   logic              mapped;
   logic [DATA_W-1:0] read_mux;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   amp_decode_t [NUM_CH-1:0] decode_reg;
   amp_decode_t [NUM_CH-1:0] decode_next;

   function automatic logic [3:0] gain_of(input logic [2:0] code);
      case (code)
         3'h0:    gain_of = 4'h1;
         3'h1:    gain_of = 4'h2;
         3'h2:    gain_of = 4'h4;
         3'h3:    gain_of = 4'h6;
         3'h4:    gain_of = 4'h8;
         3'h5:    gain_of = 4'ha;
         default: gain_of = 4'h0;
      endcase
   endfunction

   function automatic logic [16:0] ohms_of(input logic [2:0] code);
      case (code)
         3'h0:    ohms_of = 17'h000fa;
         3'h1:    ohms_of = 17'h002ee;
         3'h2:    ohms_of = 17'h007d0;
         3'h3:    ohms_of = 17'h01388;
         3'h4:    ohms_of = 17'h02710;
         3'h5:    ohms_of = 17'h04e20;
         3'h6:    ohms_of = 17'h186a0;
         default: ohms_of = 17'h00000;
      endcase
   endfunction

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         amp_channel_regs #(
            .CTL_RESET (CTL_RST[ch]),
            .CTL_WMASK (CTL_MASK[ch]),
            .HAS_CAP   (CAP_PRESENT[ch])
         ) u_regs (
            .pclk    (pclk),
            .presetn (presetn),
            .ctl_we  (ctl_we[ch]),
            .chop_we (chop_we[ch]),
            .wdata   (pwdata),
            .wstrb   (pstrb),
            .ctl_q   (ctl_q[ch]),
            .chop_q  (chop_q[ch]),
            .cfg     (amp_cfg[ch])
         );
      end
   endgenerate

   // Address decode. Only word addresses are compared, so byte offsets
   // inside a word alias onto that word.
   always_comb begin
      setup_phase  = psel && !penable;
      access_phase = psel && penable;
      read_mux     = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         ctl_hit[i]  = (paddr[ADDR_W-1:2] == CTL_OFF[i][ADDR_W-1:2]);
         chop_hit[i] = (paddr[ADDR_W-1:2] == CHOP_OFF[i][ADDR_W-1:2]);
         if (ctl_hit[i]) begin
            read_mux = ctl_q[i];
         end
         if (chop_hit[i]) begin
            read_mux = chop_q[i];
         end
      end
      mapped  = |{ctl_hit, chop_hit};
      ctl_we  = ctl_hit & {NUM_CH{access_phase && pwrite}};
      chop_we = chop_hit & {NUM_CH{access_phase && pwrite}};
   end

   // Read data is captured in the setup cycle so the zero-wait access
   // phase presents it straight from a flip-flop.
   always_comb begin
      prdata_next = prdata_reg;
      if (setup_phase) begin
         prdata_next = pwrite ? '0 : read_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = access_phase && !mapped;

   // Decoded analog settings, one cycle behind the register fields.
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         decode_next[i].gain_value =
            gain_of(amp_cfg[i].voltage_gain_sel);
         decode_next[i].resistor_ohms =
            ohms_of(amp_cfg[i].transimp_resistor_sel);
         decode_next[i].resistor_valid =
            (amp_cfg[i].transimp_resistor_sel != RES_CODE_UNDEF);
         decode_next[i].sample_time_x2 =
            !amp_cfg[i].chop_disable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decode_reg <= '0;
      end else begin
         decode_reg <= decode_next;
      end
   end

   assign amp_decode = decode_reg;

   logic wr_fire;
   assign wr_fire = access_phase && pwrite && pready;

   pd_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[1] && pstrb[0])
      |=> (amp_cfg[1].amp_core_powerdown == $past(pwdata[PD_BIT])))
      else $error("power-down bit did not follow write");

   mode_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[0] && pstrb[0])
      |=> (amp_cfg[0].tia_mode == $past(pwdata[MODE_BIT])))
      else $error("mode bit did not follow write");

   gain_decode_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (amp_cfg[1].voltage_gain_sel == 3'h3)
      |=> (amp_decode[1].gain_value == 4'h6))
      else $error("gain code 3 did not decode to 6");

   res_undef_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (amp_cfg[1].transimp_resistor_sel == RES_CODE_UNDEF)
      |=> !amp_decode[1].resistor_valid
          && (amp_decode[1].resistor_ohms == 17'h00000))
      else $error("undefined resistor code was not flagged");

   res_top_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (amp_cfg[1].transimp_resistor_sel == 3'h6)
      |=> amp_decode[1].resistor_valid
          && (amp_decode[1].resistor_ohms == 17'h186a0))
      else $error("resistor code 6 decoded wrongly");

   bias_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_fire && ctl_hit[0])
      |=> $stable(amp_cfg[0].transimp_bias_sel))
      else $error("bias select changed without a write");

   boost_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[2] && pstrb[1])
      |=> (amp_cfg[2].sink_boost_en == $past(pwdata[BOOST_BIT])))
      else $error("sink boost did not follow write");

   couple_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_phase && !pwrite && ctl_hit[3]) ##1 access_phase
      |-> (prdata[COUPLE_BIT] == amp_cfg[3].coupling_mode_sel))
      else $error("coupling bit read back wrongly");

   cap_only_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      amp_cfg[1].filter_cap_bypass && amp_cfg[3].filter_cap_bypass)
      else $error("capacitor selected on a channel without one");

   chop_time_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && chop_hit[0] && pstrb[0] && !pwdata[CHOP_BIT])
      |=> ##1 amp_decode[0].sample_time_x2)
      else $error("enabling chop did not double sample time");

   reserved_ro_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctl_q[0][31:15] == 17'h0) && !ctl_q[0][13]
      && (chop_q[2][31:1] == 31'h0))
      else $error("read-only reserved bit became nonzero");

   gain_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[1] && pstrb[0])
      |=> (amp_cfg[1].voltage_gain_sel == $past(pwdata[GAIN_LSB +: 3])))
      else $error("gain select did not follow write");

   gain_unity_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (amp_cfg[1].voltage_gain_sel == 3'h0)
      |=> (amp_decode[1].gain_value == 4'h1))
      else $error("gain code 0 did not decode to 1");

   res_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[1] && pstrb[1])
      |=> (amp_cfg[1].transimp_resistor_sel == $past(pwdata[RES_LSB +: 3])))
      else $error("resistor select did not follow write");

   bias_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[1] && pstrb[1])
      |=> (amp_cfg[1].transimp_bias_sel == $past(pwdata[BIAS_LSB +: 2])))
      else $error("bias select did not follow write");

   pd_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_fire && ctl_hit[1])
      |=> $stable(amp_cfg[1].amp_core_powerdown))
      else $error("power-down bit changed without a write");

   boost_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_fire && ctl_hit[2])
      |=> $stable(amp_cfg[2].sink_boost_en))
      else $error("sink boost changed without a write");

   mode_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_phase && !pwrite && ctl_hit[0]) ##1 access_phase
      |-> (prdata[MODE_BIT] == amp_cfg[0].tia_mode))
      else $error("mode bit read back wrongly");

   couple_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[3] && pstrb[0])
      |=> (amp_cfg[3].coupling_mode_sel == $past(pwdata[COUPLE_BIT])))
      else $error("coupling bit did not follow write");

   cap_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && ctl_hit[0] && pstrb[0])
      |=> (amp_cfg[0].filter_cap_bypass == $past(pwdata[CAP_BIT])))
      else $error("capacitor bypass did not follow write");

   chop_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && chop_hit[0] && pstrb[0])
      |=> (amp_cfg[0].chop_disable == $past(pwdata[CHOP_BIT])))
      else $error("chop disable did not follow write");

   // The flag trails the chop bit by exactly one register stage.
   sample_time_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      amp_decode[1].sample_time_x2 == !$past(amp_cfg[1].chop_disable))
      else $error("sample time flag does not follow chop disable");

   rdata_unmapped_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_phase && !pwrite && !mapped)
      |=> (prdata == 32'h0))
      else $error("unmapped read returned nonzero data");

   reserved_ctl_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctl_q[1][31:15] == 17'h0) && (ctl_q[2][31:15] == 17'h0)
      && (ctl_q[3][31:15] == 17'h0))
      else $error("reserved control bit became nonzero");

   reserved_chop_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (chop_q[0][31:1] == 31'h0) && (chop_q[1][31:1] == 31'h0)
      && (chop_q[3][31:1] == 31'h0))
      else $error("reserved chop bit became nonzero");

endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import amp_frontend_pkg::*;
   logic                     pclk;
   logic                     presetn;
   logic                     psel;
   logic                     penable;
   logic                     pwrite;
   logic [ADDR_W-1:0]        paddr;
   logic [DATA_W-1:0]        pwdata;
   logic [3:0]               pstrb;
   logic [DATA_W-1:0]        prdata;
   logic                     pready;
   logic                     pslverr;
   amp_cfg_t    [NUM_CH-1:0] amp_cfg;
   amp_decode_t [NUM_CH-1:0] amp_decode;
   int                       fails;
   int                       comparisons;
   int                       cycles;
   logic [31:0]              rd;
   logic                     err;
   logic [3:0]               gain_tab [8] =
      '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'h0, 4'h0};
   logic [16:0]              ohm_tab  [8] =
      '{17'h000fa, 17'h002ee, 17'h007d0, 17'h01388,
        17'h02710, 17'h04e20, 17'h186a0, 17'h00000};

   amp_frontend_control_regs uut (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .pstrb      (pstrb),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .amp_cfg    (amp_cfg),
      .amp_decode (amp_decode)
   );

   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   task automatic end_sim;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         end_sim();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Each transfer starts at an edge, so back-to-back calls never reassign
   // a strobe twice in one time step.
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   initial begin
      fails = 0;
      comparisons = 0;
      cycles = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
         apb(1'b0, CTL_OFF[c], 32'h0, 4'h0);
         check(rd, CTL_RST[c]);
         check({31'h0, err}, 32'h0);
         apb(1'b0, CHOP_OFF[c], 32'h0, 4'h0);
         check(rd, CHOP_RST);
         check({15'h0, amp_decode[c].resistor_ohms}, 32'h0000_00fa);
         check({28'h0, amp_decode[c].gain_value}, 32'h1);
         check({31'h0, amp_decode[c].sample_time_x2}, 32'h0);
      end
      for (int c = 0; c < NUM_CH; c++) begin
         apb(1'b1, CTL_OFF[c], 32'hffff_ffff, 4'hf);
         apb(1'b0, CTL_OFF[c], 32'h0, 4'h0);
         check(rd, CTL_MASK[c]);
         apb(1'b1, CHOP_OFF[c], 32'hffff_fffe, 4'hf);
         apb(1'b0, CHOP_OFF[c], 32'h0, 4'h0);
         check(rd, 32'h0);
      end
      apb(1'b1, CTL_OFF[2], 32'h0, 4'h1);
      apb(1'b0, CTL_OFF[2], 32'h0, 4'h0);
      check(rd, 32'h7f00);
      check({31'h0, amp_cfg[2].filter_cap_bypass}, 32'h0);
      for (int g = 0; g < 8; g++) begin
         apb(1'b1, CTL_OFF[1], (g << 5) | (g << 8) | ((g & 3) << 11), 4'hf);
         settle();
         check({28'h0, amp_decode[1].gain_value}, gain_tab[g]);
         check({15'h0, amp_decode[1].resistor_ohms}, ohm_tab[g]);
         check({31'h0, amp_decode[1].resistor_valid}, g != 7);
         check({30'h0, amp_cfg[1].transimp_bias_sel}, g & 3);
      end
      apb(1'b1, CTL_OFF[3], 32'h0000_4806, 4'hf);
      settle();
      check({31'h0, amp_cfg[3].sink_boost_en}, 32'h1);
      check({31'h0, amp_cfg[3].coupling_mode_sel}, 32'h1);
      check({31'h0, amp_cfg[3].tia_mode}, 32'h1);
      check({31'h0, amp_cfg[3].amp_core_powerdown}, 32'h0);
      check({31'h0, amp_cfg[3].filter_cap_bypass}, 32'h1);
      apb(1'b1, CTL_OFF[0], 32'h0000_0001, 4'hf);
      settle();
      check({31'h0, amp_cfg[0].filter_cap_bypass}, 32'h0);
      check({31'h0, amp_cfg[0].amp_core_powerdown}, 32'h1);
      check({31'h0, amp_cfg[0].tia_mode}, 32'h0);
      check({31'h0, amp_cfg[0].sink_boost_en}, 32'h0);
      apb(1'b1, CHOP_OFF[0], 32'h1, 4'hf);
      settle();
      check({31'h0, amp_cfg[0].chop_disable}, 32'h1);
      check({31'h0, amp_decode[0].sample_time_x2}, 32'h0);
      apb(1'b1, CHOP_OFF[0], 32'h0, 4'hf);
      settle();
      check({31'h0, amp_decode[0].sample_time_x2}, 32'h1);
      apb(1'b1, 12'h100, 32'hffff_ffff, 4'hf);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h100, 32'h0, 4'h0);
      check(rd, 32'h0);
      apb(1'b0, CTL_OFF[3], 32'h0, 4'h0);
      check(rd, 32'h4806);
      end_sim();
   end
endmodule
